// ==== shared/pbc_pkg.sv ====
// constants and types for the parallel byte capture unit
// Operation
// R1 - write config only while block disabled; config writes are accepted while the block is enabled too
// R2 - odd_select picks odd or even bytes
// R3 - skip_alternate keeps one byte in two
// R4 - sample_edge_sel picks rising or falling edge
// R5 - event_control_on lets events start/stop capture
// R6 - qualifier_mode gates sampling on qualifiers
// R7 - word_pack_size sets 8, 16, 32 bit word
// R8 - control bit 3 stops capture
// R9 - control bit 2 starts capture
// R10 - control bit 1 disables block
// R11 - control bit 0 enables block
// R12 - mask-set bits 3,2 set mask bits
// R13 - mask-clear bits clear mask bits
// R14 - writing zeros to set/clear changes nothing
// R15 - mask register reads enabled sources
// R16 - overrun sets on byte before word read
// R17 - word ready sets on complete word
// R18 - status shows capture running and enabled
// R19 - status-clear bits clear flags and request
// R20 - data register returns captured word
// R21 - version register is read-only, no effect
// R22 - first byte lands in least significant byte
// R23 - stop with partial word sets word ready; a partial word whose last byte is taken in the stop cycle is not flagged
// R24 - dma request on full word or partial stop; none for a partial word whose last byte is taken in the stop cycle
// R25 - interrupt is OR of masked flags
// R26 - external inputs synchronised, edge detected; start and stop event inputs are used unsynchronised
package pbc_pkg;
  localparam logic [7:0] PBC_OFF_CONFIG = 8'h00;
  localparam logic [7:0] PBC_OFF_CONTROL = 8'h04;
  localparam logic [7:0] PBC_OFF_IRQ_SET = 8'h08;
  localparam logic [7:0] PBC_OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] PBC_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] PBC_OFF_STATUS = 8'h14;
  localparam logic [7:0] PBC_OFF_STAT_CLR = 8'h18;
  localparam logic [7:0] PBC_OFF_DATA = 8'h1c;
  localparam logic [7:0] PBC_OFF_VERSION = 8'h20;
  localparam int PBC_BIT_ODD = 7;
  localparam int PBC_BIT_SKIP = 6;
  localparam int PBC_BIT_EDGE = 5;
  localparam int PBC_BIT_EVT = 4;
  localparam int PBC_BIT_STOP = 3;
  localparam int PBC_BIT_START = 2;
  localparam int PBC_BIT_DIS = 1;
  localparam int PBC_BIT_EN = 0;
  localparam int PBC_BIT_OVERRUN = 3;
  localparam int PBC_BIT_RDY = 2;
  localparam int PBC_BIT_CS = 1;
  localparam int PBC_BIT_ENS = 0;
  localparam logic [7:0] PBC_CONFIG_RST = 8'h00;
  localparam logic [1:0] PBC_QM_A = 2'h0;
  localparam logic [1:0] PBC_QM_AND = 2'h1;
  localparam logic [1:0] PBC_QM_OR = 2'h2;
  localparam logic [1:0] PBC_PACK_8 = 2'h0;
  localparam logic [1:0] PBC_PACK_16 = 2'h1;
  localparam logic [1:0] PBC_LAST_8 = 2'h0;
  localparam logic [1:0] PBC_LAST_16 = 2'h1;
  localparam logic [1:0] PBC_LAST_32 = 2'h3;
  localparam int PBC_SYNC_STAGES = 2;
  // arbitrary neutral identity value
  localparam logic [11:0] PBC_VERSION_VAL = 12'h123;
  localparam logic [3:0] PBC_VARIANT_VAL = 4'h0;
  typedef struct packed {
    logic clk;
    logic qual_a;
    logic qual_b;
    logic [7:0] data;
  } pbc_link_t;
  typedef struct packed {
    logic odd_select;
    logic skip_alternate;
    logic sample_edge_sel;
    logic event_control_on;
    logic [1:0] qualifier_mode;
    logic [1:0] word_pack_size;
  } pbc_config_t;
endpackage : pbc_pkg

// ==== verilog/pbc_capture.sv ====
// parallel byte capture unit with register port
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module pbc_capture #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic ext_capture_clock_in,
  input wire logic [7:0] ext_capture_data_in,
  input wire logic data_qualifier_a_in,
  input wire logic data_qualifier_b_in,
  input wire logic start_event_in,
  input wire logic stop_event_in,
  output logic irq_out,
  output logic dma_req_out
);
  pbc_pkg::pbc_config_t config_reg;
  pbc_pkg::pbc_link_t link_s1_reg, link_s2_reg;
  logic prev_clk_reg;
  logic enabled_reg, capturing_reg;
  logic [1:0] mask_reg;
  logic overrun_reg, rdy_reg;
  logic [31:0] shift_reg, data_reg;
  logic [1:0] count_reg;
  logic have_bytes_reg;
  logic parity_reg;
  logic unread_reg;
  logic dma_reg;
  logic sample_edge, qual_ok, byte_take, word_done, stop_now, flush;
  logic wr_config, wr_ctl, wr_iset, wr_iclr, wr_sclr, rd_data;

  // last byte index for a pack size
  function automatic logic [1:0] last_idx(input logic [1:0] sz);
    case (sz)
      pbc_pkg::PBC_PACK_8: last_idx = pbc_pkg::PBC_LAST_8;
      pbc_pkg::PBC_PACK_16: last_idx = pbc_pkg::PBC_LAST_16;
      default: last_idx = pbc_pkg::PBC_LAST_32;
    endcase
  endfunction : last_idx

  // register decode
  assign wr_config = wr_in && addr_in == pbc_pkg::PBC_OFF_CONFIG;
  assign wr_ctl = wr_in && addr_in == pbc_pkg::PBC_OFF_CONTROL;
  assign wr_iset = wr_in && addr_in == pbc_pkg::PBC_OFF_IRQ_SET;
  assign wr_iclr = wr_in && addr_in == pbc_pkg::PBC_OFF_IRQ_CLR;
  assign wr_sclr = wr_in && addr_in == pbc_pkg::PBC_OFF_STAT_CLR;
  assign rd_data = rd_in && addr_in == pbc_pkg::PBC_OFF_DATA;

  // two-stage synchroniser on all link inputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      link_s1_reg <= '0;
      link_s2_reg <= '0;
      prev_clk_reg <= 1'b0;
    end else begin
      link_s1_reg <= {ext_capture_clock_in, data_qualifier_a_in,
                      data_qualifier_b_in, ext_capture_data_in}; // R26
      link_s2_reg <= link_s1_reg; // R26
      prev_clk_reg <= link_s2_reg.clk;
    end
  end

  // edge select and qualifier gating
  always_comb begin
    sample_edge = config_reg.sample_edge_sel ?
                  (prev_clk_reg && !link_s2_reg.clk) :
                  (!prev_clk_reg && link_s2_reg.clk); // R4 R26
    case (config_reg.qualifier_mode)
      pbc_pkg::PBC_QM_A: qual_ok = link_s2_reg.qual_a; // R6
      pbc_pkg::PBC_QM_AND: qual_ok = link_s2_reg.qual_a
                                     && link_s2_reg.qual_b; // R6
      pbc_pkg::PBC_QM_OR: qual_ok = link_s2_reg.qual_a
                                    || link_s2_reg.qual_b; // R6
      default: qual_ok = 1'b1; // R6
    endcase
  end

  // a qualified byte that survives the alternate-byte filter
  assign byte_take = enabled_reg && capturing_reg && sample_edge && qual_ok
                     && (!config_reg.skip_alternate
                         || parity_reg == config_reg.odd_select); // R2 R3
  assign word_done = byte_take
                     && count_reg == last_idx(config_reg.word_pack_size); // R7
  assign stop_now = capturing_reg
                    && ((wr_ctl && wdata_in[pbc_pkg::PBC_BIT_STOP])
                        || (wr_ctl && wdata_in[pbc_pkg::PBC_BIT_DIS])
                        || (config_reg.event_control_on
                            && stop_event_in)); // R5 R8
  assign flush = stop_now && have_bytes_reg && !byte_take; // R23

  // configuration, software keeps it stable while enabled
  always_ff @(posedge clk_in) begin
    if (rst_in) config_reg <= pbc_pkg::PBC_CONFIG_RST;
    else if (wr_config) config_reg <= wdata_in[7:0]; // R1
  end

  // block enable and capture run state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enabled_reg <= 1'b0;
      capturing_reg <= 1'b0;
    end else begin
      if (wr_ctl && wdata_in[pbc_pkg::PBC_BIT_DIS])
        enabled_reg <= 1'b0; // R10
      else if (wr_ctl && wdata_in[pbc_pkg::PBC_BIT_EN])
        enabled_reg <= 1'b1; // R11
      if (stop_now || !enabled_reg)
        capturing_reg <= 1'b0; // R8 R5
      else if ((wr_ctl && wdata_in[pbc_pkg::PBC_BIT_START])
               || (config_reg.event_control_on && start_event_in))
        capturing_reg <= 1'b1; // R9 R5
    end
  end

  // byte parity counts every qualified byte, first is even
  always_ff @(posedge clk_in) begin
    if (rst_in) parity_reg <= 1'b0;
    else if (enabled_reg && capturing_reg && sample_edge && qual_ok)
      parity_reg <= !parity_reg; // R2
  end

  // packing, first byte in the low lane
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_reg <= '0;
      count_reg <= '0;
      have_bytes_reg <= 1'b0;
      data_reg <= '0;
    end else if (byte_take) begin
      if (word_done) begin
        data_reg <= count_reg == pbc_pkg::PBC_LAST_8 ?
                    {24'h000000, link_s2_reg.data} :
                    count_reg == pbc_pkg::PBC_LAST_16 ?
                    {16'h0000, link_s2_reg.data, shift_reg[7:0]} :
                    {link_s2_reg.data, shift_reg[23:0]}; // R22 R20
        count_reg <= '0;
        have_bytes_reg <= 1'b0;
      end else begin
        case (count_reg)
          2'h0: shift_reg[7:0] <= link_s2_reg.data; // R22
          2'h1: shift_reg[15:8] <= link_s2_reg.data; // R22
          default: shift_reg[23:16] <= link_s2_reg.data; // R22
        endcase
        count_reg <= count_reg + 2'h1;
        have_bytes_reg <= 1'b1;
      end
    end else if (flush) begin
      data_reg <= count_reg == 2'h1 ? {24'h000000, shift_reg[7:0]} :
                  count_reg == 2'h2 ? {16'h0000, shift_reg[15:0]} :
                  {8'h00, shift_reg[23:0]}; // R23
      count_reg <= '0;
      have_bytes_reg <= 1'b0;
    end
  end

  // unread tracking and sticky flags, set wins over clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      unread_reg <= 1'b0;
      overrun_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      if (word_done || flush) unread_reg <= 1'b1;
      else if (rd_data) unread_reg <= 1'b0;
      if (byte_take && unread_reg) overrun_reg <= 1'b1; // R16
      else if (wr_sclr && wdata_in[pbc_pkg::PBC_BIT_OVERRUN])
        overrun_reg <= 1'b0; // R19 R14
      if (word_done || flush) rdy_reg <= 1'b1; // R17 R23
      else if (wr_sclr && wdata_in[pbc_pkg::PBC_BIT_RDY])
        rdy_reg <= 1'b0; // R19 R14
    end
  end

  // interrupt mask set and clear
  always_ff @(posedge clk_in) begin
    if (rst_in) mask_reg <= '0;
    else if (wr_iset)
      mask_reg <= mask_reg | wdata_in[pbc_pkg::PBC_BIT_OVERRUN:
                                      pbc_pkg::PBC_BIT_RDY]; // R12 R14
    else if (wr_iclr)
      mask_reg <= mask_reg & ~wdata_in[pbc_pkg::PBC_BIT_OVERRUN:
                                       pbc_pkg::PBC_BIT_RDY]; // R13 R14
  end

  // dma request pulse on full word or flush
  always_ff @(posedge clk_in) begin
    if (rst_in) dma_reg <= 1'b0;
    else dma_reg <= word_done || flush; // R24
  end
  assign dma_req_out = dma_reg;

  // combined interrupt
  assign irq_out = (overrun_reg && mask_reg[1])
                   || (rdy_reg && mask_reg[0]); // R25

  // read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) rdata_out <= '0;
    else if (rd_in) begin
      case (addr_in)
        pbc_pkg::PBC_OFF_CONFIG: rdata_out <= {24'h000000, config_reg};
        pbc_pkg::PBC_OFF_IRQ_MASK:
          rdata_out <= {28'h0000000, mask_reg, 2'h0}; // R15
        pbc_pkg::PBC_OFF_STATUS:
          rdata_out <= {28'h0000000, overrun_reg, rdy_reg,
                        capturing_reg, enabled_reg}; // R18
        pbc_pkg::PBC_OFF_DATA: rdata_out <= data_reg; // R20
        pbc_pkg::PBC_OFF_VERSION:
          rdata_out <= {12'h000, pbc_pkg::PBC_VARIANT_VAL, 4'h0,
                        pbc_pkg::PBC_VERSION_VAL}; // R21
        default: rdata_out <= '0; // R8 R9 R10 R11
      endcase
    end else rdata_out <= '0;
  end

  // assertions
  sequence s_word;
    word_done;
  endsequence
  property p_ready_after_word;
    @(posedge clk_in) disable iff (rst_in) s_word |=> rdy_reg;
  endproperty
  a_ready_after_word: assert property (p_ready_after_word) // R17
    else $error("word ready missing");
  property p_dma;
    @(posedge clk_in) disable iff (rst_in) (word_done || flush) |=> dma_req_out;
  endproperty
  a_dma: assert property (p_dma) // R24
    else $error("dma request missing");
  property p_irq;
    @(posedge clk_in) disable iff (rst_in)
      irq_out == ((overrun_reg && mask_reg[1]) || (rdy_reg && mask_reg[0]));
  endproperty
  a_irq: assert property (p_irq) // R25
    else $error("interrupt mismatch");
  property p_start;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ctl && wdata_in == 32'h00000004 && enabled_reg) |=> capturing_reg;
  endproperty
  a_start: assert property (p_start) // R9
    else $error("start ignored");
  property p_stop;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ctl && wdata_in[pbc_pkg::PBC_BIT_STOP]) |=> !capturing_reg;
  endproperty
  a_stop: assert property (p_stop) // R8
    else $error("stop ignored");
  property p_dis;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ctl && wdata_in[pbc_pkg::PBC_BIT_DIS]) |=> !enabled_reg;
  endproperty
  a_dis: assert property (p_dis) // R10
    else $error("disable ignored");
  property p_en;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ctl && wdata_in == 32'h00000001) |=> enabled_reg;
  endproperty
  a_en: assert property (p_en) // R11
    else $error("enable ignored");
  property p_overrun;
    @(posedge clk_in) disable iff (rst_in)
      (byte_take && unread_reg) |=> overrun_reg;
  endproperty
  a_overrun: assert property (p_overrun) // R16
    else $error("overrun missing");
  property p_skip;
    @(posedge clk_in) disable iff (rst_in)
      (config_reg.skip_alternate && parity_reg != config_reg.odd_select)
      |-> !byte_take;
  endproperty
  a_skip: assert property (p_skip) // R3
    else $error("skipped byte taken");
  property p_clr;
    @(posedge clk_in) disable iff (rst_in)
      (wr_iclr && wdata_in[pbc_pkg::PBC_BIT_RDY]) |=> !mask_reg[0];
  endproperty
  a_clr: assert property (p_clr) // R13
    else $error("mask not cleared");
  // mask set bit reaches the mask
  property p_mask_set;
    @(posedge clk_in) disable iff (rst_in)
      (wr_iset && wdata_in[pbc_pkg::PBC_BIT_OVERRUN]) |=> mask_reg[1];
  endproperty
  a_mask_set: assert property (p_mask_set) // R12
    else $error("mask not set");
  // zero writes leave the mask alone
  property p_zero_write;
    @(posedge clk_in) disable iff (rst_in)
      ((wr_iset || wr_iclr)
       && wdata_in[pbc_pkg::PBC_BIT_OVERRUN:pbc_pkg::PBC_BIT_RDY] == 2'h0)
      |=> $stable(mask_reg);
  endproperty
  a_zero_write: assert property (p_zero_write) // R14
    else $error("mask moved on zero write");
  // status clear drops the ready flag unless a new word lands
  property p_status_clear;
    @(posedge clk_in) disable iff (rst_in)
      (wr_sclr && wdata_in[pbc_pkg::PBC_BIT_RDY] && !word_done && !flush)
      |=> !rdy_reg;
  endproperty
  a_status_clear: assert property (p_status_clear) // R19
    else $error("ready flag not cleared");
  // a partial word on stop still raises ready
  property p_flush_ready;
    @(posedge clk_in) disable iff (rst_in) flush |=> rdy_reg;
  endproperty
  a_flush_ready: assert property (p_flush_ready) // R23
    else $error("partial word not flagged");
  // the opening byte of a wider word goes to the low lane
  sequence s_first_byte;
    byte_take && !word_done && count_reg == 2'h0;
  endsequence
  property p_first_lane;
    @(posedge clk_in) disable iff (rst_in)
      s_first_byte |=> shift_reg[7:0] == $past(link_s2_reg.data);
  endproperty
  a_first_lane: assert property (p_first_lane) // R22
    else $error("first byte not in low lane");
  // second stage follows the first one cycle later
  property p_sync;
    @(posedge clk_in) disable iff (rst_in) link_s2_reg == $past(link_s1_reg);
  endproperty
  a_sync: assert property (p_sync) // R26
    else $error("synchroniser stage skipped");
  // capture cannot run in a disabled block
  property p_capture_needs_enable;
    @(posedge clk_in) disable iff (rst_in) !enabled_reg |=> !capturing_reg;
  endproperty
  a_capture_needs_enable: assert property (p_capture_needs_enable) // R18
    else $error("capture running while disabled");
  // command bits always read back as zero
  property p_control_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
      (rd_in && addr_in == pbc_pkg::PBC_OFF_CONTROL) |=> rdata_out == 32'h0;
  endproperty
  a_control_reads_zero: assert property (p_control_reads_zero) // R8
    else $error("control bits read nonzero");
  // version field reads the fixed value
  property p_version;
    @(posedge clk_in) disable iff (rst_in)
      (rd_in && addr_in == pbc_pkg::PBC_OFF_VERSION)
      |=> rdata_out[11:0] == pbc_pkg::PBC_VERSION_VAL;
  endproperty
  a_version: assert property (p_version) // R21
    else $error("version field wrong");
  // mask register reports the enabled sources
  property p_mask_read;
    @(posedge clk_in) disable iff (rst_in)
      (rd_in && addr_in == pbc_pkg::PBC_OFF_IRQ_MASK)
      |=> rdata_out[pbc_pkg::PBC_BIT_OVERRUN:pbc_pkg::PBC_BIT_RDY]
          == $past(mask_reg);
  endproperty
  a_mask_read: assert property (p_mask_read) // R15
    else $error("mask read wrong");
endmodule : pbc_capture

// ==== bench/pbc_src_model.sv ====
// model of the external byte source that drives the capture pins
`timescale 1ns/1ps
module pbc_src_model (
  output pbc_pkg::pbc_link_t link_out
);
  // the link clock stands low between byte frames
  initial begin
    link_out = '0;
  end
  // one frame: the true byte shows only at the chosen edge, stale data inverts
  task automatic send(input logic [7:0] d, input logic qa, input logic qb,
                      input logic fall);
    link_out.qual_a = qa;
    link_out.qual_b = qb;
    link_out.data = fall ? ~d : d;
    #32 link_out.clk = 1'b1;
    #16 link_out.data = fall ? d : ~d;
    #16 link_out.clk = 1'b0;
    #16 link_out.data = ~link_out.data;
    link_out.qual_a = ~qa;
    link_out.qual_b = ~qb;
  endtask : send
endmodule : pbc_src_model

// ==== bench/parallel_byte_capture_tb_top.sv ====
// self-checking bench for the parallel byte capture unit
`timescale 1ns/1ps
module parallel_byte_capture_tb_top;
  logic clk_in, rst_in, wr_in, rd_in, start_ev, stop_ev, irq_out, dma_req_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, rv, exp_w;
  logic par, kept;
  pbc_pkg::pbc_link_t link;
  pbc_pkg::pbc_config_t cur_mode;
  integer seed;
  int n_fail, comparisons, dma_n, dma0, cnt, nb;
  pbc_capture uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_capture_clock_in(link.clk),
    .ext_capture_data_in(link.data), .data_qualifier_a_in(link.qual_a),
    .data_qualifier_b_in(link.qual_b), .start_event_in(start_ev),
    .stop_event_in(stop_ev), .irq_out(irq_out), .dma_req_out(dma_req_out));
  pbc_src_model src (.link_out(link));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // count dma pulses
  always @(posedge clk_in) begin
    if (dma_req_out === 1'b1) dma_n <= dma_n + 1;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd
  task automatic pulse(input logic stop);
    @(posedge clk_in);
    if (stop) stop_ev <= 1'b1;
    else start_ev <= 1'b1;
    @(posedge clk_in);
    stop_ev <= 1'b0;
    start_ev <= 1'b0;
  endtask : pulse
  function automatic logic qual_ok(logic [1:0] m, logic a, logic b);
    if (m == pbc_pkg::PBC_QM_A) return a;
    if (m == pbc_pkg::PBC_QM_AND) return a & b;
    if (m == pbc_pkg::PBC_QM_OR) return a | b;
    return 1'b1;
  endfunction : qual_ok
  // send one byte and work out where it should land
  task automatic push(input logic [7:0] d, input logic qa, input logic qb);
    src.send(d, qa, qb, cur_mode.sample_edge_sel);
    kept = 1'b0;
    if (qual_ok(cur_mode.qualifier_mode, qa, qb)) begin
      kept = !cur_mode.skip_alternate || (par == cur_mode.odd_select);
      par = ~par;
    end
    if (kept) exp_w = exp_w | (32'(d) << (8 * cnt));
    if (kept) cnt++;
    repeat (6) @(posedge clk_in);
  endtask : push
  // configure only while disabled, then enable and start
  task automatic setup(input logic [7:0] c);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h2);
    cur_mode = c;
    wr(pbc_pkg::PBC_OFF_CONFIG, {24'h0, c});
    rd(pbc_pkg::PBC_OFF_CONFIG);
    check(rv, {24'h0, c});
    wr(pbc_pkg::PBC_OFF_STAT_CLR, 32'hc);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h1);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h4);
    exp_w = 32'h0;
    cnt = 0;
    nb = (c[1:0] == pbc_pkg::PBC_PACK_8) ? 1 :
         (c[1:0] == pbc_pkg::PBC_PACK_16) ? 2 : 4;
    dma0 = dma_n;
  endtask : setup
  // watchdog
  initial begin
    #400000;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial begin
    seed = 32'h46aee483;
    {rst_in, wr_in, rd_in, start_ev, stop_ev, par} = 6'h20;
    {addr_in, wdata_in, n_fail, comparisons, dma_n} = '0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a <= 'h24; a += 4) begin
      rd(8'(a));
      check(rv, (a == 'h20) ? {12'h0, pbc_pkg::PBC_VARIANT_VAL, 4'h0,
        pbc_pkg::PBC_VERSION_VAL} : 32'h0);
    end
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h4);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h0);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h1);
    pulse(1'b0);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h1);
    rd(pbc_pkg::PBC_OFF_CONTROL);
    check(rv, 32'h0);
    $display("reset and control test done");
    for (int t = 0; t < 16; t++) begin
      rv = $random(seed);
      setup(rv[7:0] & 8'hef);
      for (int k = 0; k < 60 && cnt < nb; k++) begin
        rv = $random(seed);
        push(rv[7:0], rv[8], rv[9]);
      end
      if (cnt < nb) wr(pbc_pkg::PBC_OFF_CONTROL, 32'h8);
      rd(pbc_pkg::PBC_OFF_STATUS);
      check(rv, (cnt == nb) ? 32'h7 : (cnt > 0) ? 32'h5 : 32'h1);
      rd(pbc_pkg::PBC_OFF_DATA);
      check(rv, exp_w);
      check(32'(dma_n - dma0), {31'h0, cnt > 0});
    end
    $display("random capture test done");
    setup(8'h0c);
    push(8'h5a, 1'b0, 1'b0);
    push(8'ha5, 1'b0, 1'b0);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'hf);
    rd(pbc_pkg::PBC_OFF_DATA);
    check(rv, 32'ha5);
    setup(8'h0e);
    push(8'h3c, 1'b0, 1'b0);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h8);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h5);
    rd(pbc_pkg::PBC_OFF_DATA);
    check(rv, 32'h3c);
    $display("overrun and flush test done");
    wr(pbc_pkg::PBC_OFF_IRQ_SET, 32'h0);
    rd(pbc_pkg::PBC_OFF_IRQ_MASK);
    check(rv, 32'h0);
    check({31'h0, irq_out}, 32'h0);
    wr(pbc_pkg::PBC_OFF_IRQ_SET, 32'hc);
    rd(pbc_pkg::PBC_OFF_IRQ_MASK);
    check(rv, 32'hc);
    check({31'h0, irq_out}, 32'h1);
    wr(pbc_pkg::PBC_OFF_IRQ_CLR, 32'h4);
    rd(pbc_pkg::PBC_OFF_IRQ_MASK);
    check(rv + {31'h0, irq_out}, 32'h8);
    wr(pbc_pkg::PBC_OFF_IRQ_SET, 32'h4);
    wr(pbc_pkg::PBC_OFF_STAT_CLR, 32'h0);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv + {31'h0, irq_out}, 32'h6);
    wr(pbc_pkg::PBC_OFF_STAT_CLR, 32'h4);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv + {31'h0, irq_out}, 32'h1);
    $display("interrupt test done");
    setup(8'h1c);
    pulse(1'b1);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h1);
    pulse(1'b0);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h3);
    wr(pbc_pkg::PBC_OFF_CONTROL, 32'h2);
    rd(pbc_pkg::PBC_OFF_STATUS);
    check(rv, 32'h0);
    $display("event and disable test done");
    complete_run();
  end
endmodule : parallel_byte_capture_tb_top
